// *** epg_pkg.sv ***
// constants for the eight-pin general-purpose port and its register map
// assumes an AXI4-Lite master with 32-bit data and a 10 MHz system clock
package epg_pkg;
   localparam int PINS = 8;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;
   localparam int IDX_W = 12;
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_OPEN_DRAIN = 12'h801;
   localparam logic [IDX_W-1:0] IDX_DRIVE_LEVEL = 12'h802;
   localparam logic [IDX_W-1:0] IDX_INPUT_STATUS = 12'h804;
   localparam logic [IDX_W-1:0] IDX_DRIVE_ENABLE = 12'h805;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h806;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h807;
   // field layout of the input register
   localparam int LEVEL_LSB = 0;
   localparam int FLAG_LSB = 8;
   // reset values
   localparam logic [PINS-1:0] RST_OPEN_DRAIN = 8'h00;
   localparam logic [PINS-1:0] RST_DRIVE_LEVEL = 8'h00;
   localparam logic [PINS-1:0] RST_DRIVE_ENABLE = 8'h00;
   localparam logic [PINS-1:0] RST_IRQ_MASK = 8'h00;
   localparam logic [PINS-1:0] RST_PIN = 8'h00;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
   // one-hot register selects
   localparam int SEL_W = 6;
   localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
   localparam logic [SEL_W-1:0] SEL_OPEN_DRAIN = 6'h01;
   localparam logic [SEL_W-1:0] SEL_DRIVE_LEVEL = 6'h02;
   localparam logic [SEL_W-1:0] SEL_INPUT_STATUS = 6'h04;
   localparam logic [SEL_W-1:0] SEL_DRIVE_ENABLE = 6'h08;
   localparam logic [SEL_W-1:0] SEL_IRQ_STATUS = 6'h10;
   localparam logic [SEL_W-1:0] SEL_IRQ_MASK = 6'h20;
endpackage

// *** epg_flag_bank.sv ***
// sticky per-pin flags: set by hardware, cleared in bulk by a clear mask
// assumes set and clear are synchronous one-cycle terms of the same clock
`timescale 1ns/10ps
module epg_flag_bank
   import epg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [PINS-1:0] setBits,
   input wire logic [PINS-1:0] clearBits,
   output logic [PINS-1:0] flags,
   output logic [PINS-1:0] newlySet
);
   logic [PINS-1:0] flags_r;
   logic [PINS-1:0] flags_nxt;

   // a set in the clearing cycle survives
   assign flags_nxt = setBits | (flags_r & ~clearBits);
   assign flags = flags_r;
   assign newlySet = setBits & ~flags_r;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         flags_r <= RST_PIN;
      else
         flags_r <= flags_nxt;
   end
endmodule

// *** epg_port_top.sv ***
// eight general-purpose pins with open-drain select, drive level and input status
// registers on an AXI4-Lite slave; pins and analog-busy flags are synchronous inputs
//
// How it works
// RULE_01: per-pin open-drain select, read-write bits 7:0, reset zero.
// RULE_02: bits 15:8 of select and level registers read zero, writes ignored.
// RULE_03: per-pin drive level, read-write bits 7:0, reads back, reset zero.
// RULE_04: read-only input register: detect flags in 15:8, pin levels in 7:0.
// RULE_05: reading the input register clears every detect flag it returned.
// RULE_06: each level bit shows the current sampled pin level.
// RULE_07: drive only with drive-enable set and no analog measurement on the pin.
// RULE_08: flag sets on any cycle the sampled level is high, sticky.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module epg_port_top
   import epg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [PINS-1:0] pinIn,
   input wire logic [PINS-1:0] analogBusy,
   output logic [PINS-1:0] pinOut,
   output logic [PINS-1:0] pinOe_n,
   output logic irq
);
   // unaligned and unmapped addresses decode to no register, which answers with an error
   function automatic logic [SEL_W-1:0] regSelect(input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      idx = addr[ADDR_W-1:2];
      if (addr[1:0] != 2'h0)
         regSelect = SEL_NONE;
      else if (idx == IDX_OPEN_DRAIN)
         regSelect = SEL_OPEN_DRAIN;
      else if (idx == IDX_DRIVE_LEVEL)
         regSelect = SEL_DRIVE_LEVEL;
      else if (idx == IDX_INPUT_STATUS)
         regSelect = SEL_INPUT_STATUS;
      else if (idx == IDX_DRIVE_ENABLE)
         regSelect = SEL_DRIVE_ENABLE;
      else if (idx == IDX_IRQ_STATUS)
         regSelect = SEL_IRQ_STATUS;
      else if (idx == IDX_IRQ_MASK)
         regSelect = SEL_IRQ_MASK;
      else
         regSelect = SEL_NONE;
   endfunction

   // register state
   logic [PINS-1:0] openDrainSel_r;
   logic [PINS-1:0] driveLevel_r;
   logic [PINS-1:0] driveEnable_r;
   logic [PINS-1:0] irqStatus_r;
   logic [PINS-1:0] irqMask_r;
   logic [PINS-1:0] pinLevel_r;
   logic [PINS-1:0] pinOut_r;
   logic [PINS-1:0] pinOeN_r;
   logic irq_r;

   // write channel state
   logic awHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic wHeld_r;
   logic [DATA_W-1:0] wData_r;
   logic [3:0] wStrb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;

   // read channel state
   logic arready_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;

   // handshakes and decode
   wire awFire = s_axi_awvalid && awready_r;
   wire wFire = s_axi_wvalid && wready_r;
   wire bFire = bvalid_r && s_axi_bready;
   wire arFire = s_axi_arvalid && arready_r;
   wire rFire = rvalid_r && s_axi_rready;
   wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
   wire [SEL_W-1:0] wrSel = regSelect(awAddr_r);
   wire [SEL_W-1:0] rdSel = regSelect(s_axi_araddr);
   // RULE_02 reserved bits ignored
   // only the low byte lane carries field bits; upper lanes hold reserved bits
   // so a write with the low strobe off answers okay and changes nothing
   wire laneLow = wStrb_r[0];
   wire [PINS-1:0] wrByte = wData_r[PINS-1:0];

   wire awHeld_nxt = awFire ? 1'b1 : (doWrite ? 1'b0 : awHeld_r);
   wire wHeld_nxt = wFire ? 1'b1 : (doWrite ? 1'b0 : wHeld_r);
   wire bvalid_nxt = doWrite ? 1'b1 : (bFire ? 1'b0 : bvalid_r);
   wire [1:0] bresp_nxt = doWrite ? ((wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY) : bresp_r;
   wire rvalid_nxt = arFire ? 1'b1 : (rFire ? 1'b0 : rvalid_r);

   // high-detect flags
   wire [PINS-1:0] detectFlags;
   wire [PINS-1:0] detectNew;
   // RULE_05 read clears flags
   // only flags already returned are cleared, so a high seen in this very cycle is kept
   wire rdInput = arFire && rdSel == SEL_INPUT_STATUS;
   wire [PINS-1:0] readClear = rdInput ? detectFlags : RST_PIN;

   // RULE_08 sticky high detect
   // set from the sampled level, so a flag trails its level bit by one cycle and stays set after the level falls
   epg_flag_bank u_detect (
      .clock(clock),
      .rst_n(rst_n),
      .setBits(pinLevel_r),
      .clearBits(readClear),
      .flags(detectFlags),
      .newlySet(detectNew)
   );

   // field write enables; the input register has none, so a write to it only answers
   // RULE_01 open-drain select write
   wire wrOpenDrain = doWrite && laneLow && wrSel == SEL_OPEN_DRAIN;
   // RULE_03 drive level write
   wire wrDriveLevel = doWrite && laneLow && wrSel == SEL_DRIVE_LEVEL;
   wire wrDriveEnable = doWrite && laneLow && wrSel == SEL_DRIVE_ENABLE;
   wire wrIrqMask = doWrite && laneLow && wrSel == SEL_IRQ_MASK;
   wire [PINS-1:0] irqW1c = (doWrite && laneLow && wrSel == SEL_IRQ_STATUS) ? wrByte : RST_PIN;

   // new detect events set status; a set beats a same-cycle write-one clear
   wire [PINS-1:0] irqStatus_nxt = detectNew | (irqStatus_r & ~irqW1c);
   // the level output is registered so it never glitches on a status write
   wire irq_nxt = |(irqStatus_nxt & irqMask_r);

   // read data mux; reserved bits stay zero
   // RULE_02 upper bits read zero
   // RULE_04 input word layout
   wire [15:0] inputWord = {detectFlags, pinLevel_r};
   wire [DATA_W-1:0] rdWord =
      (rdSel == SEL_OPEN_DRAIN) ? {24'h000000, openDrainSel_r} :
      (rdSel == SEL_DRIVE_LEVEL) ? {24'h000000, driveLevel_r} :
      (rdSel == SEL_INPUT_STATUS) ? {16'h0000, inputWord} :
      (rdSel == SEL_DRIVE_ENABLE) ? {24'h000000, driveEnable_r} :
      (rdSel == SEL_IRQ_STATUS) ? {24'h000000, irqStatus_r} :
      (rdSel == SEL_IRQ_MASK) ? {24'h000000, irqMask_r} : DATA_ZERO;
   wire [1:0] rdResp = (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

   // RULE_07 drive gating
   // analog measurement overrides the enable without altering it
   wire [PINS-1:0] driveActive = driveEnable_r & ~analogBusy;
   wire [PINS-1:0] pinOut_nxt;
   wire [PINS-1:0] pinOeN_nxt;

   genvar p;
   generate
      for (p = 0; p < PINS; p++)
      begin : g_drive
         // RULE_01 open-drain per pin
         // open-drain only pulls low; a high level releases the pin to its pull-up
         wire pushPull = !openDrainSel_r[p];
         wire wantLow = !driveLevel_r[p];
         // RULE_03 level per pin
         // a released open-drain pin shows 0 here so the pad never sees a stray high
         assign pinOut_nxt[p] = driveLevel_r[p] && pushPull;
         assign pinOeN_nxt[p] = !(driveActive[p] && (pushPull || wantLow));
      end
   endgenerate

   // AXI write channels
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= DATA_ZERO;
         wStrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else
      begin
         // ready is withheld while a response waits, so one write at most is in flight
         awHeld_r <= awHeld_nxt;
         wHeld_r <= wHeld_nxt;
         if (awFire)
            awAddr_r <= s_axi_awaddr;
         if (wFire)
         begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         awready_r <= !awHeld_nxt && !bvalid_nxt;
         wready_r <= !wHeld_nxt && !bvalid_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // AXI read channels
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= DATA_ZERO;
         rresp_r <= RESP_OKAY;
      end
      else
      begin
         // arready stays low while data waits; one read at most is in flight
         arready_r <= !rvalid_nxt;
         rvalid_r <= rvalid_nxt;
         if (arFire)
         begin
            rdata_r <= rdWord;
            rresp_r <= rdResp;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         openDrainSel_r <= RST_OPEN_DRAIN;
         driveLevel_r <= RST_DRIVE_LEVEL;
         driveEnable_r <= RST_DRIVE_ENABLE;
         irqMask_r <= RST_IRQ_MASK;
      end
      else
      begin
         // RULE_01 select stored
         if (wrOpenDrain)
            openDrainSel_r <= wrByte;
         // RULE_03 level stored
         if (wrDriveLevel)
            driveLevel_r <= wrByte;
         if (wrDriveEnable)
            driveEnable_r <= wrByte;
         if (wrIrqMask)
            irqMask_r <= wrByte;
      end
   end

   // pin sampling, pin drive and interrupt
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pinLevel_r <= RST_PIN;
         pinOut_r <= RST_PIN;
         // all pins released while in reset
         pinOeN_r <= 8'hff;
         irqStatus_r <= RST_PIN;
         irq_r <= 1'b0;
      end
      else
      begin
         // RULE_06 pin level sample
         // pins are taken as synchronous, so one register stage is enough
         pinLevel_r <= pinIn;
         pinOut_r <= pinOut_nxt;
         pinOeN_r <= pinOeN_nxt;
         irqStatus_r <= irqStatus_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign pinOut = pinOut_r;
   assign pinOe_n = pinOeN_r;
   assign irq = irq_r;
endmodule

// *** epg_pin_model.sv ***
// outside circuitry on the eight pins: pull-ups plus a strong source from the bench
// assumes the bench owns extDrive and extVal and changes them just after a clock edge
`timescale 1ns/10ps
module epg_pin_model
   import epg_pkg::*;
(
   input wire logic clock,
   input wire logic [PINS-1:0] pinOut,
   input wire logic [PINS-1:0] pinOe_n,
   input wire logic [PINS-1:0] extDrive,
   input wire logic [PINS-1:0] extVal,
   output logic [PINS-1:0] pinIn
);
   // a released pin reads high through its pull-up; the strong source beats the port
   wire logic [PINS-1:0] wireLvl = (extDrive & extVal) | (~extDrive & (pinOe_n | pinOut));
   initial pinIn = 8'h00;
   always @(posedge clock)
   begin
      pinIn <= wireLvl;
   end
endmodule

// *** epg_port_top_props.sv ***
// checker for the pin port: bus timing, reserved bits and the analog override
// assumes it is bound to epg_port_top and sees only its ports
`timescale 1ns/10ps
module epg_port_top_props
   import epg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [PINS-1:0] analogBusy,
   input wire logic [PINS-1:0] pinOe_n,
   input wire logic irq
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_reset_quiet: assert property (disable iff (1'h0)
      !rst_n |=> pinOe_n == 8'hff && !irq && !s_axi_bvalid) else $error("not quiet in reset");
   a_write_answer: assert property (s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_analog_off: assert property (1'h1 |=> (~pinOe_n & $past(analogBusy)) == 8'h00)
      else $error("drive during analog use");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper bits set");
endmodule
bind epg_port_top epg_port_top_props u_props (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .analogBusy, .pinOe_n, .irq);

// *** eight_pin_gpio_regs_bench.sv ***
// self-checking bench for the pin port over its AXI4-Lite slave
// assumes the pin model on the pins and one 10 MHz clock
`timescale 1ns/10ps
module eight_pin_gpio_regs_bench;
   import epg_pkg::*;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
   logic [DATA_W-1:0] s_axi_wdata = 32'h00000000;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [PINS-1:0] analogBusy = 8'h00, extDrive = 8'hff, extVal = 8'h00;
   logic [3:0] wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [DATA_W-1:0] s_axi_rdata;
   logic [PINS-1:0] pinIn, pinOut, pinOe_n;
   int fails = 0, comparisons = 0, cycles = 0;
   epg_port_top DUT (.clock, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .pinIn, .analogBusy, .pinOut, .pinOe_n, .irq);
   epg_pin_model u_pins (.clock, .pinOut, .pinOe_n, .extDrive, .extVal, .pinIn);
   always #50 clock = ~clock;
   task stop_test;
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fails++;
         stop_test;
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // bready and rready come one cycle late so the slave must hold its answer
   task wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do @(posedge clock); while (!s_axi_bvalid);
      s_axi_bready <= 1'h1;
      @(posedge clock);
      s_axi_bready <= 1'h0;
      check(32'(s_axi_bresp), 32'(er));
   endtask
   task rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge clock); while (!s_axi_rvalid);
      s_axi_rready <= 1'h1;
      @(posedge clock);
      s_axi_rready <= 1'h0;
      check(s_axi_rdata, exp);
      check(32'(s_axi_rresp), 32'(er));
   endtask
   initial
   begin
      repeat (12) @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      rd(IDX_OPEN_DRAIN, 32'h0, RESP_OKAY);
      rd(IDX_DRIVE_LEVEL, 32'h0, RESP_OKAY);
      rd(IDX_INPUT_STATUS, 32'h0, RESP_OKAY);
      wr(IDX_OPEN_DRAIN, 32'hffffa5a5, RESP_OKAY);
      rd(IDX_OPEN_DRAIN, 32'ha5, RESP_OKAY);
      wr(IDX_DRIVE_LEVEL, 32'h0000ff3c, RESP_OKAY);
      rd(IDX_DRIVE_LEVEL, 32'h3c, RESP_OKAY);
      wstrb <= 4'he;
      wr(IDX_DRIVE_LEVEL, 32'h000000ff, RESP_OKAY);
      wstrb <= 4'hf;
      rd(IDX_DRIVE_LEVEL, 32'h3c, RESP_OKAY);
      wr(IDX_INPUT_STATUS, 32'hffff, RESP_OKAY);
      rd(IDX_INPUT_STATUS, 32'h0, RESP_OKAY);
      wr(12'h803, 32'h1, RESP_SLVERR);
      rd(12'h803, DATA_ZERO, RESP_SLVERR);
      wr(IDX_IRQ_MASK, 32'h01, RESP_OKAY);
      extVal <= 8'h81;
      repeat (3) @(posedge clock);
      extVal <= 8'h00;
      repeat (3) @(posedge clock);
      check(32'(irq), 32'h1);
      rd(IDX_INPUT_STATUS, 32'h8100, RESP_OKAY);
      rd(IDX_INPUT_STATUS, 32'h0, RESP_OKAY);
      wr(IDX_IRQ_STATUS, 32'h01, RESP_OKAY);
      rd(IDX_IRQ_STATUS, 32'h80, RESP_OKAY);
      check(32'(irq), 32'h0);
      wr(IDX_DRIVE_ENABLE, 32'hff, RESP_OKAY);
      extDrive <= 8'h00;
      repeat (4) @(posedge clock);
      check(32'(pinOe_n), 32'h24);
      check(32'(pinOut), 32'h18);
      rd(IDX_INPUT_STATUS, 32'h3c3c, RESP_OKAY);
      analogBusy <= 8'h0f;
      repeat (4) @(posedge clock);
      check(32'(pinOe_n), 32'h2f);
      check(32'(pinOut), 32'h18);
      rd(IDX_INPUT_STATUS, 32'h3f3f, RESP_OKAY);
      rd(IDX_DRIVE_ENABLE, 32'hff, RESP_OKAY);
      stop_test;
   end
endmodule
